// [design/cpu_flag_and_mode_logic.sv]
`timescale 1ns/1ps
// Function
// - eight-bit flag byte, bits 6 and 5 one
// - signed overflow sets signed_wrap_flag
// - add sets nibble_carry_flag on bit-3 carry
// - decimal adjust uses nibble and borrow flags
// - gate blocks interrupts, set after stacking
// - entry never stacks upper index byte
// - highest-priority pending request served first
// - return restores stacked flags and gate
// - reset sets gate, release, return, doze and halt clear it
// - result bit 7 drives result_msb_flag
// - zero result sets equal_flag
// - carry or borrow sets borrow_out_flag
// - doze clears gate, stops core clock
// - halt clears gate, settle before restart
// - break loads trap opcode and vector
// - break starts at instruction completion
// - return in break ends it if released
// - immediate adds to pointers, two cycles
// - branch on carry clear, three cycles
module cpu_flag_and_mode_logic
    import flag_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic break_req,
    input wire logic monitor_mode,
    // core state
    output logic [7:0] flag_out,
    output logic [15:0] pc_out,
    output logic [7:0] ir_out,
    output logic core_clk_en,
    output logic break_active
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        state_e st;
        logic [7:0] flag;
        logic [7:0] acc;
        logic [7:0] opnd;
        logic [7:0] res;
        logic [15:0] sp;
        logic [15:0] hx;
        logic [15:0] pc;
        logic [7:0] ir;
        logic [7:0] stk;
        logic [15:0] cnt;
        logic brk_act;
        logic [NUM_IRQ+1:0] s1;
        logic [NUM_IRQ+1:0] s2;
        logic [31:0] rdata;
        logic err;
    } core_s;

    localparam core_s CORE_RST = '{st: ST_RUN, flag: FLAG_RST, sp: SP_RST, default: '0};
    core_s q;
    core_s d;
    logic [NUM_IRQ-1:0] irq_s;
    logic brk_s;
    logic mon_s;
    logic hit;
    logic wr;
    logic launch;
    logic [7:0] cmd;
    logic take_brk;
    logic take_irq;
    logic pend;
    logic [1:0] sel;
    logic cin;
    logic [8:0] sum9;
    logic [4:0] lo5;
    logic [8:0] dif9;
    logic [7:0] and_r;
    logic [7:0] corr;
    logic [8:0] daa9;
    logic [3:0] stat;
    assign irq_s = q.s2[NUM_IRQ-1:0];
    assign brk_s = q.s2[NUM_IRQ];
    assign mon_s = q.s2[NUM_IRQ+1];
    assign cmd = pwdata[7:0];
    assign wr = psel & penable & pwrite & hit;
    assign launch = wr & (paddr == OFF_CMD) & (q.st == ST_RUN);
    assign pready = 1'b1;
    assign pslverr = psel & penable & q.err;
    assign prdata = q.rdata;
    assign flag_out = q.flag;
    assign pc_out = q.pc;
    assign ir_out = q.ir;
    assign break_active = q.brk_act;
    assign core_clk_en = (q.st == ST_RUN) | (q.st == ST_BUSY);

    // ----------------------------------------
    // flag helper
    // ----------------------------------------
    function automatic logic [7:0] with_nz(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[B_N] = r[7];
        o[B_Z] = (r == 8'h00);
        return o;
    endfunction

    // ----------------------------------------
    // address decode and status
    // ----------------------------------------
    always_comb begin
        unique case (paddr)
            OFF_FLAG, OFF_OPND, OFF_CMD, OFF_RES, OFF_PTR, OFF_PC, OFF_STK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        stat = 4'h0;
        stat[STAT_BUSY] = (q.st == ST_BUSY);
        stat[STAT_DOZE] = (q.st == ST_DOZE);
        stat[STAT_HALT] = (q.st == ST_HALT) | (q.st == ST_SETTLE);
        stat[STAT_BRK] = q.brk_act;
    end

    // ----------------------------------------
    // arithmetic
    // ----------------------------------------
    always_comb begin
        cin = (cmd == CMD_ADC) & q.flag[B_C];
        sum9 = {1'b0, q.acc} + {1'b0, q.opnd} + {8'h00, cin};
        lo5 = {1'b0, q.acc[3:0]} + {1'b0, q.opnd[3:0]} + {4'h0, cin};
        dif9 = {1'b0, q.acc} - {1'b0, q.opnd};
        and_r = q.acc & q.opnd;
        corr = 8'h00;
        if (q.flag[B_H] | (q.acc[3:0] > BCD_LO_MAX)) begin
            corr[3:0] = BCD_FIX;
        end
        if (q.flag[B_C] | (q.acc > BCD_MAX)) begin
            corr[7:4] = BCD_FIX;
        end
        daa9 = {1'b0, q.acc} + {1'b0, corr};
    end

    // ----------------------------------------
    // pending request priority, lowest index wins
    // ----------------------------------------
    always_comb begin
        sel = 2'd0;
        pend = |irq_s;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_s[i]) begin
                sel = 2'(i);
            end
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        take_brk = 1'b0;
        take_irq = 1'b0;
        d.s1 = {monitor_mode, break_req, irq_req};
        d.s2 = q.s1;
        if (psel & ~penable) begin
            d.err = ~hit;
            unique case (paddr)
                OFF_FLAG: d.rdata = {24'h0, q.flag};
                OFF_OPND: d.rdata = {16'h0, q.opnd, q.acc};
                OFF_CMD: d.rdata = {28'h0, stat};
                OFF_RES: d.rdata = {24'h0, q.res};
                OFF_PTR: d.rdata = {q.hx, q.sp};
                OFF_PC: d.rdata = {8'h0, q.ir, q.pc};
                OFF_STK: d.rdata = {24'h0, q.stk};
                default: d.rdata = 32'h0;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                OFF_FLAG: begin
                    // gate untouched by writes
                    d.flag = (pwdata[7:0] & ~(8'h01 << B_I)) | (q.flag & (8'h01 << B_I)) | FIXED_ONES;
                end
                OFF_OPND: begin
                    d.acc = pwdata[7:0];
                    d.opnd = pwdata[15:8];
                end
                OFF_PTR: begin
                    d.sp = pwdata[15:0];
                    d.hx = pwdata[31:16];
                end
                OFF_PC: d.pc = pwdata[15:0];
                OFF_STK: d.stk = pwdata[7:0] | FIXED_ONES;
                default: d.err = q.err;
            endcase
        end
        unique case (q.st)
            ST_RUN: begin
                if (launch) begin
                    unique case (cmd)
                        CMD_ADD, CMD_ADC: begin
                            d.res = sum9[7:0];
                            d.acc = sum9[7:0];
                            d.flag = with_nz(q.flag, sum9[7:0]);
                            d.flag[B_H] = lo5[4];
                            d.flag[B_C] = sum9[8];
                            d.flag[B_V] = (q.acc[7] == q.opnd[7]) & (sum9[7] != q.acc[7]);
                        end
                        CMD_SUB: begin
                            d.res = dif9[7:0];
                            d.acc = dif9[7:0];
                            d.flag = with_nz(q.flag, dif9[7:0]);
                            d.flag[B_C] = dif9[8];
                            d.flag[B_V] = (q.acc[7] != q.opnd[7]) & (dif9[7] != q.acc[7]);
                        end
                        CMD_AND: begin
                            d.res = and_r;
                            d.acc = and_r;
                            d.flag = with_nz(q.flag, and_r);
                            d.flag[B_V] = 1'b0;
                        end
                        CMD_ASL: begin
                            d.res = {q.acc[6:0], 1'b0};
                            d.acc = {q.acc[6:0], 1'b0};
                            d.flag = with_nz(q.flag, {q.acc[6:0], 1'b0});
                            d.flag[B_C] = q.acc[7];
                            d.flag[B_V] = q.acc[7] ^ q.acc[6];
                        end
                        CMD_DAA: begin
                            d.res = daa9[7:0];
                            d.acc = daa9[7:0];
                            d.flag = with_nz(q.flag, daa9[7:0]);
                            d.flag[B_C] = (corr[7:4] == BCD_FIX);
                        end
                        CMD_AIS: begin
                            d.sp = q.sp + {{8{q.opnd[7]}}, q.opnd};
                            d.st = ST_BUSY;
                            d.cnt = CYC_IMM_ADD - 16'd1;
                        end
                        CMD_AIX: begin
                            d.hx = q.hx + {{8{q.opnd[7]}}, q.opnd};
                            d.st = ST_BUSY;
                            d.cnt = CYC_IMM_ADD - 16'd1;
                        end
                        CMD_BCC: begin
                            d.pc = q.pc + 16'd2;
                            if (!q.flag[B_C]) begin
                                d.pc = q.pc + 16'd2 + {{8{q.opnd[7]}}, q.opnd};
                            end
                            d.st = ST_BUSY;
                            d.cnt = CYC_BCC - 16'd1;
                        end
                        CMD_CLI: d.flag[B_I] = 1'b0;
                        CMD_RTI: begin
                            d.flag = q.stk | FIXED_ONES;
                            if (q.brk_act & ~brk_s) begin
                                d.brk_act = 1'b0;
                            end
                        end
                        CMD_DOZE: begin
                            d.flag[B_I] = 1'b0;
                            d.st = ST_DOZE;
                        end
                        CMD_HALT: begin
                            d.flag[B_I] = 1'b0;
                            d.st = ST_HALT;
                        end
                        default: d.res = q.res;
                    endcase
                end else if (brk_s & ~q.brk_act) begin
                    take_brk = 1'b1;
                end else if (pend & ~q.flag[B_I]) begin
                    take_irq = 1'b1;
                end
            end
            ST_BUSY: begin
                d.cnt = q.cnt - 16'd1;
                if (q.cnt == 16'd1) begin
                    d.st = ST_RUN;
                    take_brk = brk_s & ~q.brk_act;
                end
            end
            ST_DOZE: begin
                if (pend) begin
                    d.st = ST_RUN;
                end
            end
            ST_HALT: begin
                if (pend) begin
                    d.st = ST_SETTLE;
                    d.cnt = SETTLE_CYC - 16'd1;
                end
            end
            ST_SETTLE: begin
                d.cnt = q.cnt - 16'd1;
                if (q.cnt == 16'd0) begin
                    d.st = ST_RUN;
                    d.cnt = 16'd0;
                end
            end
        endcase
        // only flags are stacked, never the upper index byte
        if (take_brk) begin
            d.ir = TRAP_OPCODE;
            d.pc = mon_s ? BRK_MON_VEC : BRK_VEC;
            d.stk = q.flag;
            d.flag[B_I] = 1'b1;
            d.brk_act = 1'b1;
        end else if (take_irq) begin
            d.stk = q.flag;
            d.flag[B_I] = 1'b1;
            d.pc = IRQ_VEC_TOP - {13'h0, sel, 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fixed_ones: assert property (flag_out[6:5] == 2'b11)
        else $error("flag byte fixed bits not one");
    a_gate_release: assert property ($fell(flag_out[B_I]) |-> $past(launch))
        else $error("gate cleared without a command");
    a_entry_stack: assert property (take_irq |=> flag_out[B_I] && q.stk[B_I] == 1'b0)
        else $error("interrupt entry ordering wrong");
    a_irq_prio: assert property (take_irq && irq_s[0] |=> pc_out == IRQ_VEC_TOP)
        else $error("lowest index not served first");
    a_half_carry: assert property (launch && cmd == CMD_ADD |=>
        flag_out[B_H] == ($past(q.acc[3:0]) > ~$past(q.opnd[3:0])))
        else $error("nibble carry flag wrong");
    a_zero_flag: assert property (launch && cmd == CMD_AND |=> flag_out[B_Z] == (q.res == 8'h00))
        else $error("equal flag disagrees with result");
    a_imm_add_time: assert property (launch && cmd == CMD_AIS |=> q.st == ST_BUSY ##1 q.st == ST_RUN)
        else $error("stack add not two cycles");
    a_bcc_time: assert property (launch && cmd == CMD_BCC |=> (q.st == ST_BUSY)[*2] ##1 q.st == ST_RUN)
        else $error("branch not three cycles");
    a_bcc_flags: assert property (launch && cmd == CMD_BCC |=> $stable(flag_out))
        else $error("branch altered flags");
    a_brk_vector: assert property (take_brk |=> ir_out == TRAP_OPCODE &&
        pc_out == ($past(mon_s) ? BRK_MON_VEC : BRK_VEC))
        else $error("break entry vector wrong");
    a_doze_gate: assert property (launch && cmd == CMD_DOZE |=> !flag_out[B_I] && !core_clk_en)
        else $error("doze did not clear gate and clock");
    a_halt_settle: assert property ($rose(q.st == ST_SETTLE) |-> !core_clk_en [*8])
        else $error("clock resumed before settle");
    c_irq_entry: cover property (take_irq);
    c_brk_entry: cover property (take_brk ##[1:50] (launch && cmd == CMD_RTI));
    c_halt_wake: cover property (q.st == ST_SETTLE ##1 q.st == ST_RUN);
    c_doze_wake: cover property (q.st == ST_DOZE ##1 q.st == ST_RUN);
endmodule

// [design/flag_pkg.sv]
package flag_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_FLAG = 8'h00;
    localparam logic [7:0] OFF_OPND = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_RES = 8'h0C;
    localparam logic [7:0] OFF_PTR = 8'h10;
    localparam logic [7:0] OFF_PC = 8'h14;
    localparam logic [7:0] OFF_STK = 8'h18;
    // ----------------------------------------
    // flag byte layout and reset values
    // ----------------------------------------
    localparam int B_V = 7;
    localparam int B_H = 4;
    localparam int B_I = 3;
    localparam int B_N = 2;
    localparam int B_Z = 1;
    localparam int B_C = 0;
    localparam logic [7:0] FIXED_ONES = 8'h60;
    localparam logic [7:0] FLAG_RST = 8'h68;
    localparam logic [15:0] SP_RST = 16'h00FF;
    // ----------------------------------------
    // status bits of the command register
    // ----------------------------------------
    localparam int STAT_BUSY = 0;
    localparam int STAT_DOZE = 1;
    localparam int STAT_HALT = 2;
    localparam int STAT_BRK = 3;
    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_ADD = 8'hAB;
    localparam logic [7:0] CMD_ADC = 8'hA9;
    localparam logic [7:0] CMD_AND = 8'hA4;
    localparam logic [7:0] CMD_ASL = 8'h48;
    localparam logic [7:0] CMD_AIS = 8'hA7;
    localparam logic [7:0] CMD_AIX = 8'hAF;
    localparam logic [7:0] CMD_BCC = 8'h24;
    localparam logic [7:0] CMD_SUB = 8'h01;
    localparam logic [7:0] CMD_DAA = 8'h02;
    localparam logic [7:0] CMD_CLI = 8'h03;
    localparam logic [7:0] CMD_RTI = 8'h04;
    localparam logic [7:0] CMD_DOZE = 8'h05;
    localparam logic [7:0] CMD_HALT = 8'h06;
    // arbitrary value
    localparam logic [7:0] TRAP_OPCODE = 8'h5A;
    // ----------------------------------------
    // vectors, bcd limits, timing
    // ----------------------------------------
    localparam logic [15:0] BRK_VEC = 16'hFFFC;
    localparam logic [15:0] BRK_MON_VEC = 16'hFEFC;
    localparam logic [15:0] IRQ_VEC_TOP = 16'hFFFA;
    localparam int NUM_IRQ = 4;
    localparam logic [3:0] BCD_LO_MAX = 4'h9;
    localparam logic [7:0] BCD_MAX = 8'h99;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [15:0] CYC_IMM_ADD = 16'd2;
    localparam logic [15:0] CYC_BCC = 16'd3;
    localparam int CLK_NS = 10;
    localparam int SETTLE_NS = 1000;
    localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
    // ----------------------------------------
    // core states
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_BUSY = 5'b00010,
        ST_DOZE = 5'b00100,
        ST_HALT = 5'b01000,
        ST_SETTLE = 5'b10000
    } state_e;
endpackage

// [tb/test_cpu_flag_and_mode_logic.sv]
`timescale 1ns/1ps
module test_cpu_flag_and_mode_logic
    import flag_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_IRQ-1:0] irq_req = '0;
    logic break_req = 1'b0;
    logic monitor_mode = 1'b0;
    logic [7:0] flag_out;
    logic [15:0] pc_out;
    logic [7:0] ir_out;
    logic core_clk_en;
    logic break_active;
    int errors = 0;
    int total_checks = 0;
    logic [31:0] rv;
    logic re;
    logic [7:0] ff;
    int n;
    // pre flags, command, acc, operand, result, flags after
    localparam logic [47:0] ALU_TBL [9] = '{
        {8'h00, CMD_ADD, 8'h78, 8'h08, 8'h80, 8'hFC},
        {8'h00, CMD_ADD, 8'hFF, 8'h01, 8'h00, 8'h7B},
        {8'h01, CMD_ADC, 8'h01, 8'h01, 8'h03, 8'h68},
        {8'h11, CMD_AND, 8'hF0, 8'h0F, 8'h00, 8'h7B},
        {8'h00, CMD_SUB, 8'h00, 8'h01, 8'hFF, 8'h6D},
        {8'h00, CMD_ASL, 8'h81, 8'h00, 8'h02, 8'hE9},
        {8'h00, CMD_DAA, 8'h0A, 8'h00, 8'h10, 8'h68},
        {8'h01, CMD_DAA, 8'h12, 8'h00, 8'h72, 8'h69},
        {8'h10, CMD_DAA, 8'h12, 8'h00, 8'h18, 8'h78}
    };
    always #5 pclk = ~pclk;
    cpu_flag_and_mode_logic cpu_flag_and_mode_logic_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_req(irq_req), .break_req(break_req), .monitor_mode(monitor_mode),
        .flag_out(flag_out), .pc_out(pc_out), .ir_out(ir_out), .core_clk_en(core_clk_en),
        .break_active(break_active)
    );
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] acc, input logic [7:0] m);
        wr(OFF_OPND, {16'h0, m, acc});
        wr(OFF_CMD, {24'h0, c});
        tick(2);
        do begin
            rd(OFF_CMD);
        end while (rv[STAT_BUSY] !== 1'b0);
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        tick(4);
        presetn <= 1'b1;
        rd(OFF_FLAG);
        chk(rv, 32'h68);
        rd(OFF_PTR);
        chk({16'h0, rv[15:0]}, {16'h0, SP_RST});
        wr(OFF_FLAG, 32'h00);
        rd(OFF_FLAG);
        chk(rv, 32'h68);
        wr(OFF_FLAG, 32'h97);
        rd(OFF_FLAG);
        chk(rv, 32'hFF);
        rd(8'h1C);
        chk({31'h0, re}, 32'h1);
        wr(8'h1C, 32'h0);
        chk({31'h0, re}, 32'h1);
        for (int i = 0; i < 9; i++) begin
            wr(OFF_FLAG, {24'h0, ALU_TBL[i][47:40]});
            cmd(ALU_TBL[i][39:32], ALU_TBL[i][31:24], ALU_TBL[i][23:16]);
            rd(OFF_RES);
            chk(rv, {24'h0, ALU_TBL[i][15:8]});
            chk({24'h0, flag_out}, {24'h0, ALU_TBL[i][7:0]});
        end
        // immediate pointer adds and branch
        wr(OFF_PTR, {16'h1234, 16'h00FF});
        ff = flag_out;
        cmd(CMD_AIS, 8'h00, 8'h80);
        cmd(CMD_AIX, 8'h00, 8'h05);
        rd(OFF_PTR);
        chk(rv, {16'h1239, 16'h007F});
        chk({24'h0, flag_out}, {24'h0, ff});
        wr(OFF_FLAG, 32'h00);
        wr(OFF_PC, 32'h1000);
        cmd(CMD_BCC, 8'h00, 8'hF0);
        chk({16'h0, pc_out}, 32'h0FF2);
        wr(OFF_FLAG, 32'h01);
        cmd(CMD_BCC, 8'h00, 8'h10);
        chk({16'h0, pc_out}, 32'h0FF4);
        chk({24'h0, flag_out}, 32'h69);
        // masked then released interrupts
        irq_req <= 4'b0110;
        tick(6);
        chk({16'h0, pc_out}, 32'h0FF4);
        cmd(CMD_CLI, 8'h00, 8'h00);
        tick(4);
        chk({16'h0, pc_out}, {16'h0, IRQ_VEC_TOP - 16'h0002});
        chk({31'h0, flag_out[B_I]}, 32'h1);
        rd(OFF_STK);
        chk({31'h0, rv[B_I]}, 32'h0);
        rd(OFF_PTR);
        chk({16'h0, rv[31:16]}, 32'h1239);
        irq_req <= '0;
        cmd(CMD_RTI, 8'h00, 8'h00);
        chk({31'h0, flag_out[B_I]}, 32'h0);
        // doze, woken by interrupt
        cmd(CMD_DOZE, 8'h00, 8'h00);
        chk({31'h0, core_clk_en}, 32'h0);
        chk({31'h0, flag_out[B_I]}, 32'h0);
        irq_req <= 4'b1000;
        n = 0;
        while (core_clk_en !== 1'b1 && n < 50) begin
            n++;
            tick(1);
        end
        chk({31'h0, core_clk_en}, 32'h1);
        tick(4);
        chk({16'h0, pc_out}, {16'h0, IRQ_VEC_TOP - 16'h0006});
        irq_req <= '0;
        cmd(CMD_RTI, 8'h00, 8'h00);
        // halt, settle delay before restart
        cmd(CMD_HALT, 8'h00, 8'h00);
        chk({31'h0, core_clk_en}, 32'h0);
        chk({31'h0, flag_out[B_I]}, 32'h0);
        irq_req <= 4'b0101;
        n = 0;
        while (core_clk_en !== 1'b1 && n < 300) begin
            n++;
            tick(1);
        end
        chk({31'h0, n >= 100 && n <= 106}, 32'h1);
        tick(4);
        chk({16'h0, pc_out}, {16'h0, IRQ_VEC_TOP});
        irq_req <= '0;
        cmd(CMD_RTI, 8'h00, 8'h00);
        // break entry and return
        break_req <= 1'b1;
        tick(6);
        chk({24'h0, ir_out}, {24'h0, TRAP_OPCODE});
        chk({16'h0, pc_out}, {16'h0, BRK_VEC});
        chk({31'h0, break_active}, 32'h1);
        cmd(CMD_RTI, 8'h00, 8'h00);
        chk({31'h0, break_active}, 32'h1);
        break_req <= 1'b0;
        tick(4);
        cmd(CMD_RTI, 8'h00, 8'h00);
        chk({31'h0, break_active}, 32'h0);
        monitor_mode <= 1'b1;
        tick(3);
        break_req <= 1'b1;
        tick(6);
        chk({16'h0, pc_out}, {16'h0, BRK_MON_VEC});
        break_req <= 1'b0;
        tick(4);
        cmd(CMD_RTI, 8'h00, 8'h00);
        monitor_mode <= 1'b0;
        // doze, woken by reset
        cmd(CMD_DOZE, 8'h00, 8'h00);
        presetn <= 1'b0;
        tick(4);
        presetn <= 1'b1;
        tick(1);
        chk({24'h0, flag_out}, {24'h0, FLAG_RST});
        chk({31'h0, core_clk_en}, 32'h1);
        chk({31'h0, break_active}, 32'h0);
        end_of_test();
    end
endmodule
